// File: hw/slt_regs.sv
// SCL low-time timer and I/O supply select registers
`default_nettype none
`include "slt_params.svh"

module slt_regs
    import slt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       io_supply_rail,
    input  wire logic       scl_low_start,
    output logic            scl_drive_low,
    output logic            scl_low_done,
    input  wire logic       sda_setup_start,
    output logic            scl_hold_low,
    output logic            sda_setup_done,
    output logic            io_high_voltage_select,
    output logic      [1:0] io_supply_mode
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [`SLT_CNT_W-1:0] low_cycles(input logic [7:0] count);
        logic [`SLT_CNT_W-1:0] units;
        units = `SLT_CNT_W'(count) + `SLT_CNT_W'(`SLT_EXTRA_PERIODS);
        return `SLT_CNT_W'(units * `SLT_CNT_W'(`SLT_UNIT_CYC));
    endfunction

    // One-hot register select, shared by the write and read paths
    function automatic logic [2:0] reg_hit(input logic [7:0] addr);
        logic [2:0] hit_v;
        hit_v = 3'h0;
        case (addr)
            `SLT_OFS_SCL_LOW:
            begin
                hit_v = 3'h1;
            end
            `SLT_OFS_SPARE:
            begin
                hit_v = 3'h2;
            end
            `SLT_OFS_IO_SUPPLY:
            begin
                hit_v = 3'h4;
            end
            default:
            begin
                hit_v = 3'h0;
            end
        endcase
        return hit_v;
    endfunction

    slt_state_t cur;
    slt_state_t next_cur;
    logic       next_sel;
    logic [1:0] next_mode;
    logic [2:0] hit;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_cur = cur;
        next_cur.low_done = 1'b0;
        next_cur.setup_done = 1'b0;
        next_cur.rvalid = 1'b0;

        // Register select from the offset
        hit = reg_hit(reg_addr);

        // Supply level sampled through two flops
        next_cur.rail_meta = io_supply_rail;
        next_cur.rail_sync = cur.rail_meta;

        // Register writes
        if (reg_write)
        begin
            unique case (hit)
                3'h1:
                begin
                    next_cur.scl_low_period = reg_wdata;
                end
                3'h2:
                begin
                    next_cur.spare_slot = reg_wdata;
                end
                3'h4:
                begin
                    next_cur.sel_written = reg_wdata[`SLT_BIT_SEL];
                    next_cur.supply_mode_override = reg_wdata[`SLT_BIT_OVR];
                    next_cur.mode_written = reg_wdata[`SLT_MODE_HI:`SLT_MODE_LO];
                    next_cur.supply_reserved = reg_wdata[`SLT_RSVD_HI:`SLT_RSVD_LO];
                end
                default:
                begin
                end
            endcase
        end

        // Effective supply controls
        if (cur.supply_mode_override)
        begin
            next_sel = cur.sel_written;                                 // [R6]
            next_mode = cur.mode_written;                               // [R6]
        end
        else
        begin
            next_sel = cur.rail_sync;                                   // [R4] [R5]
            next_mode = cur.rail_sync ? `SLT_MODE_3V3 : `SLT_MODE_1V8;  // [R5] [R6]
        end
        next_cur.io_high_voltage_select = next_sel;
        next_cur.io_supply_mode = next_mode;

        // Register reads, one cycle later
        if (reg_read)
        begin
            next_cur.rvalid = 1'b1;
            unique case (hit)
                3'h1:
                begin
                    next_cur.rdata = cur.scl_low_period;
                end
                3'h2:
                begin
                    next_cur.rdata = cur.spare_slot;
                end
                3'h4:
                begin
                    next_cur.rdata = {cur.io_high_voltage_select,             // [R4]
                                      cur.supply_mode_override,
                                      cur.io_supply_mode,
                                      cur.supply_reserved};
                end
                default:
                begin
                    next_cur.rdata = 8'h00;
                end
            endcase
        end

        // SCL low phase as bus controller
        if (cur.low_active)
        begin
            if (cur.low_cnt == '0)
            begin
                next_cur.low_active = 1'b0;
                next_cur.low_done = 1'b1;
            end
            else
            begin
                next_cur.low_cnt = cur.low_cnt - `SLT_CNT_W'(1);
            end
        end
        // A start while the phase runs is ignored
        else if (scl_low_start)
        begin
            next_cur.low_active = 1'b1;
            next_cur.low_cnt = low_cycles(cur.scl_low_period) - `SLT_CNT_W'(1); // [R1]
        end

        // SDA setup before releasing SCL as target
        if (cur.setup_active)
        begin
            if (cur.setup_cnt == '0)
            begin
                next_cur.setup_active = 1'b0;
                next_cur.setup_done = 1'b1;
            end
            else
            begin
                next_cur.setup_cnt = cur.setup_cnt - `SLT_CNT_W'(1);
            end
        end
        // A start while the phase runs is ignored
        else if (sda_setup_start)
        begin
            next_cur.setup_active = 1'b1;
            next_cur.setup_cnt = low_cycles(cur.scl_low_period) - `SLT_CNT_W'(1); // [R2]
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cur <= '0;
            cur.scl_low_period <= `SLT_RST_SCL_LOW;                     // [R3]
            cur.spare_slot <= `SLT_RST_SPARE;
            cur.sel_written <= 1'(`SLT_RST_IO_SUPPLY >> `SLT_BIT_SEL);
            cur.supply_mode_override <= 1'b0;
            cur.mode_written <= 2'(`SLT_RST_IO_SUPPLY >> `SLT_MODE_LO);
            cur.supply_reserved <= 4'(`SLT_RST_IO_SUPPLY);
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = cur.rdata;
    assign reg_rvalid = cur.rvalid;
    assign scl_drive_low = cur.low_active;
    assign scl_low_done = cur.low_done;
    assign scl_hold_low = cur.setup_active;
    assign sda_setup_done = cur.setup_done;
    assign io_high_voltage_select = cur.io_high_voltage_select;
    assign io_supply_mode = cur.io_supply_mode;

endmodule

`default_nettype wire

// File: hw/slt_params.svh
// Constants of the SCL timing and I/O supply register slice
//
// Function
// (R1) SCL low pulse lasts 40 ns times the count plus four oscillator periods.
// (R2) The same count times the target SDA setup before SCL is released.
// (R3) The SCL low-time count resets to 0x7a, about 100 kHz at 25 MHz.
// (R4) Voltage select bit: 0 is 1.8 V, 1 is 3.3 V; reads detected level. With override set the code reads back the written bit.
// (R5) With override clear, select and mode follow the detected supply level.
// (R6) With override set, written select and mode apply; mode 00 1.8 V, 11 3.3 V.
// (R7) Software allows for a ten percent oscillator spread when choosing counts.
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SLT_OFS_SCL_LOW      8'h0b
`define SLT_OFS_SPARE        8'h0c
`define SLT_OFS_IO_SUPPLY    8'h0d

// ****************************************
// Reset values
// ****************************************
`define SLT_RST_SCL_LOW      8'h7a
`define SLT_RST_SPARE        8'h00
`define SLT_RST_IO_SUPPLY    8'h09

// ****************************************
// Field positions of the supply register
// ****************************************
`define SLT_BIT_SEL          7
`define SLT_BIT_OVR          6
`define SLT_MODE_HI          5
`define SLT_MODE_LO          4
`define SLT_RSVD_HI          3
`define SLT_RSVD_LO          0
`define SLT_MODE_1V8         2'h0
`define SLT_MODE_3V3         2'h3

// ****************************************
// Timing
// ****************************************
`define SLT_CLK_MHZ          200
`define SLT_UNIT_NS          40
`define SLT_UNIT_CYC         ((`SLT_UNIT_NS * `SLT_CLK_MHZ + 999) / 1000)
`define SLT_EXTRA_PERIODS    4
`define SLT_CNT_W            12

`endif

// File: hw/slt_pkg.sv
// Types of the SCL timing and I/O supply register slice
`default_nettype none
`include "slt_params.svh"

package slt_pkg;

    typedef struct packed {
        logic [7:0]            scl_low_period;
        logic [7:0]            spare_slot;
        logic                  supply_mode_override;
        logic                  sel_written;
        logic [1:0]            mode_written;
        logic [3:0]            supply_reserved;
        logic                  rail_meta;
        logic                  rail_sync;
        logic [`SLT_CNT_W-1:0] low_cnt;
        logic                  low_active;
        logic                  low_done;
        logic [`SLT_CNT_W-1:0] setup_cnt;
        logic                  setup_active;
        logic                  setup_done;
        logic                  io_high_voltage_select;
        logic [1:0]            io_supply_mode;
        logic [7:0]            rdata;
        logic                  rvalid;
    } slt_state_t;

endpackage

`default_nettype wire

// File: tb/slt_regs_assertions.sv
// Concurrent checks on the SCL timer and supply register slice ports
`default_nettype none
`include "slt_params.svh"
module slt_regs_assertions
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic       reg_rvalid,
    input wire logic       io_supply_rail,
    input wire logic       scl_low_start,
    input wire logic       scl_drive_low,
    input wire logic       scl_low_done,
    input wire logic       sda_setup_start,
    input wire logic       scl_hold_low,
    input wire logic       sda_setup_done,
    input wire logic       io_high_voltage_select,
    input wire logic [1:0] io_supply_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic [2:0] wf_q;
    logic       ov_q;
    logic [2:0] rdy_q;
    int         lo_n;
    int         lo_e;
    int         su_n;
    int         su_e;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Shadow of the written fields and phase length counters
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_q <= 8'h7a;
            wf_q  <= 3'h0;
            ov_q  <= 1'b0;
            rdy_q <= 3'h0;
            lo_n  <= 0;
            su_n  <= 0;
        end
        else
        begin
            rdy_q <= (rdy_q == 3'h4) ? rdy_q : rdy_q + 3'h1;
            if (reg_write && reg_addr == 8'h0b)
                cnt_q <= reg_wdata;
            if (reg_write && reg_addr == 8'h0d)
            begin
                wf_q <= {reg_wdata[7], reg_wdata[5:4]};
                ov_q <= reg_wdata[6];
            end
            if (scl_low_start && !scl_drive_low)
            begin
                lo_n <= 0;
                lo_e <= `SLT_UNIT_CYC * (cnt_q + `SLT_EXTRA_PERIODS);
            end
            else if (scl_drive_low)
                lo_n <= lo_n + 1;
            if (sda_setup_start && !scl_hold_low)
            begin
                su_n <= 0;
                su_e <= `SLT_UNIT_CYC * (cnt_q + `SLT_EXTRA_PERIODS);
            end
            else if (scl_hold_low)
                su_n <= su_n + 1;
        end
    end
    rd_answer_a: assert property (reg_rvalid == $past(reg_read))
        else $error("read not answered");
    low_len_a: assert property (scl_low_done |-> lo_n == lo_e)
        else $error("scl low width wrong");
    low_edge_a: assert property ($fell(scl_drive_low) |-> scl_low_done)
        else $error("scl low done missing");
    setup_len_a: assert property (sda_setup_done |-> su_n == su_e)
        else $error("sda setup width wrong");
    setup_edge_a: assert property ($fell(scl_hold_low) |-> sda_setup_done)
        else $error("sda setup done missing");
    supply_eff_a: assert property (rdy_q == 3'h4 |->
        {io_high_voltage_select, io_supply_mode} == ($past(ov_q) ? $past(wf_q)
        : {3{$past(io_supply_rail, 3)}}))
        else $error("supply controls wrong");
endmodule
bind slt_regs slt_regs_assertions chk (.*);
`default_nettype wire

// File: tb/slt_host.sv
// Host model driving the register strobe port
`default_nettype none
module slt_host
(
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the SCL timer and supply register slice
`default_nettype none
`include "slt_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       reset_n, rail, lo_go, su_go, wr_s, rd_s, rv, lo_on, lo_dn, su_on, su_dn, sel;
    logic [1:0] mode;
    logic [7:0] addr, wdata, rdata, d;
    logic [7:0] cv [3] = '{8'h7a, 8'h00, 8'hff};
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    always #2.5 clk = ~clk;
    slt_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .reg_rvalid(rv),
        .io_supply_rail(rail), .scl_low_start(lo_go), .scl_drive_low(lo_on),
        .scl_low_done(lo_dn), .sda_setup_start(su_go), .scl_hold_low(su_on),
        .sda_setup_done(su_dn), .io_high_voltage_select(sel), .io_supply_mode(mode));
    slt_host host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .reg_rdata(rdata));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk("reg_rdata", e, d);
    endtask
    task automatic timer(input logic s, input logic [7:0] c);
        int n;
        n = 0;
        @(posedge clk);
        lo_go <= !s;
        su_go <= s;
        @(posedge clk);
        lo_go <= 1'b0;
        su_go <= 1'b0;
        @(negedge clk);
        while ((s ? su_on : lo_on) === 1'b1 && n < 3000)
        begin
            n++;
            @(negedge clk);
        end
        chk("phase length", 16'(`SLT_UNIT_CYC * (c + `SLT_EXTRA_PERIODS)), n[15:0]);
        chk("done pulse", 16'h1, {15'h0, s ? su_dn : lo_dn});
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop;
        end
    end
    initial
    begin
        {reset_n, rail, lo_go, su_go} = 4'h0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rchk(8'h0b, 8'h7a);
        rchk(8'h0d, 8'h09);
        rchk(8'h33, 8'h00);
        $display("test reset values done");
        rail <= 1'b1;
        repeat (4) @(posedge clk);
        chk("supply outputs", 16'h7, {sel, mode});
        rchk(8'h0d, 8'hb9);
        host.wr(8'h0d, 8'h00);
        rchk(8'h0d, 8'hb0);
        host.wr(8'h0d, 8'h40);
        rchk(8'h0d, 8'h40);
        chk("supply outputs", 16'h0, {sel, mode});
        host.wr(8'h0d, 8'hf5);
        rail <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(8'h0d, 8'hf5);
        chk("supply outputs", 16'h7, {sel, mode});
        host.wr(8'h0d, 8'h05);
        rchk(8'h0d, 8'h05);
        $display("test supply select done");
        for (int i = 0; i < 3; i++)
        begin
            if (i > 0)
                host.wr(8'h0b, cv[i]);
            rchk(8'h0b, cv[i]);
            timer(1'b0, cv[i]);
            timer(1'b1, cv[i]);
        end
        $display("test timers done");
        report_and_stop;
    end
endmodule
`default_nettype wire
